// [rtl/power_state_controller.sv]
`timescale 1ns/1ns
// Summary of operation
// - key high past filter, battery present: power-on reset then Normal
// - qualification timer rejects short key transients
// - key high enables regulator and host supplies, sensor supply if control one bit 4 is set
// - once enabled, outputs follow their control registers or inputs
// - during power-on reset outputs off, open-load detect on, registers to defaults
// - key low and hold low: Sleep, supplies off, key-status low
// - Sleep turns off every output, source and sink except open-load detect
// - key rising in Sleep wakes regulator and issues power-on reset
// - key high: Normal, supplies on, key-status high in key-follow mode, hold ignored
// - hold bit in control register one enables prepare-to-shutdown
// - prepare-to-shutdown: supplies on, outputs off, relay two kept only while relay_two_shutdown_disable is high
// - only hold bit or key high ends shutdown; host writes zero to reach Sleep
// - key level readable in the status register
// - self-test bit 6 disconnects status, host may write ones
// - otherwise host only clears status bits, hardware sets them
// - clearing self-test restores status defaults and sources
// - watchdog reset clears self-test; host ends test before timeout
// - key-follow: key-status output equals key level
// - config bit 7 picks key-follow or spi high-side drive
// - high-side drive can be pulse-width modulated for an led
// - config bits 1-0: none, 100 Hz, 1 kHz, external pin /100
// - 7-bit duty in 1% steps, codes above 100 saturate
// - hold bit is control one bit 7: 0 Sleep, 1 shutdown prep
module power_state_controller
	import power_state_pkg::*;
#(
	parameter int KEY_FILTER_CYCLES = KEY_FILTER_DEFAULT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins from the vehicle
	input wire logic key_switch_in,
	input wire logic battery_supply,
	input wire logic ext_pwm_in,
	// spi pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// on-chip sources
	input wire logic [3:0] fault_in,
	input wire logic watchdog_reset,
	input wire logic relay_two_shutdown_disable,
	// power and output control
	output supplies_t supplies,
	output logic outputs_enable,
	output logic relay_two_enable,
	output logic open_load_detect_en,
	output logic power_on_reset,
	output power_state_t state,
	output logic key_status_output_pin
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_m, pin_s;
	logic sclk_d, cs_d, ext_d, cs_m, cs_s;
	always_ff @(posedge clk) begin
		pin_m <= {key_switch_in, battery_supply, ext_pwm_in, spi_sclk, spi_si};
		pin_s <= pin_m;
		sclk_d <= pin_s[1];
		ext_d <= pin_s[2];
		cs_d <= cs_s;
	end
	always_ff @(posedge clk) begin
		cs_m <= spi_cs_n;
		cs_s <= cs_m;
	end
	wire key_s = pin_s[4];
	wire batt_s = pin_s[3];
	wire si_s = pin_s[0];

	// ----------------------------------------------------------------
	// spi slave
	// ----------------------------------------------------------------
	// sampled by clk, so sclk must stay well below clk/4
	logic [15:0] rx, tx, next_rx, next_tx;
	logic [4:0] bits, next_bits;
	logic [3:0] last_addr, next_last_addr;
	logic commit, next_commit, next_so;
	logic [7:0] ctrl, key_cfg, status;
	logic [6:0] duty;
	logic [7:0] rd_data;
	always_comb begin
		unique case (last_addr)
			REG_CTRL1: rd_data = ctrl;
			REG_KEY_CFG: rd_data = key_cfg;
			REG_DUTY: rd_data = {1'b0, duty};
			REG_STATUS: rd_data = status;
			default: rd_data = 8'h00;
		endcase
	end
	always_comb begin
		next_rx = rx;
		next_tx = tx;
		next_bits = bits;
		next_so = spi_so;
		next_commit = 1'b0;
		next_last_addr = last_addr;
		if (cs_d && !cs_s) begin
			next_bits = 5'h00;
			next_tx = {8'h00, rd_data};
			next_so = 1'b0;
		end else if (!cs_s && pin_s[1] && !sclk_d) begin
			next_rx = {rx[14:0], si_s};
			next_bits = bits + 5'h01;
		end else if (!cs_s && !pin_s[1] && sclk_d) begin
			next_tx = {tx[14:0], 1'b0};
			next_so = tx[14];
		end else if (!cs_d && cs_s && bits == FRAME_BITS) begin
			next_commit = rx[FRAME_WR];
			next_last_addr = rx[11:8];
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rx <= 16'h0000;
			tx <= 16'h0000;
			bits <= 5'h00;
			spi_so <= 1'b0;
			spi_so_oe <= 1'b0;
			commit <= 1'b0;
			last_addr <= 4'h0;
		end else begin
			rx <= next_rx;
			tx <= next_tx;
			bits <= next_bits;
			spi_so <= next_so;
			spi_so_oe <= !cs_s;
			commit <= next_commit;
			last_addr <= next_last_addr;
		end
	end
	wire [3:0] wr_addr = last_addr;
	wire [7:0] wr_data = rx[7:0];

	// ----------------------------------------------------------------
	// key filter and power states
	// ----------------------------------------------------------------
	logic key_q, next_key_q;
	logic [15:0] key_cnt, next_key_cnt;
	power_state_t next_state;
	supplies_t next_supplies;
	logic next_por;
	always_comb begin
		next_key_q = key_q;
		next_key_cnt = 16'h0000;
		if (key_s != key_q) begin
			if (key_cnt == 16'(KEY_FILTER_CYCLES - 1))
				next_key_q = key_s;
			else
				next_key_cnt = key_cnt + 16'h0001;
		end
		next_state = state;
		next_por = 1'b0;
		unique case (state)
			PS_SLEEP: if (key_q && batt_s) begin
				next_state = PS_NORMAL;
				next_por = 1'b1;
			end
			PS_NORMAL: if (!key_q)
				next_state = ctrl[CTRL_PWREN] ? PS_PREP : PS_SLEEP;
			PS_PREP: if (key_q)
				next_state = PS_NORMAL;
			else if (!ctrl[CTRL_PWREN])
				next_state = PS_SLEEP;
			default: next_state = PS_SLEEP;
		endcase
		next_supplies.regulator = next_state != PS_SLEEP;
		next_supplies.host = next_state != PS_SLEEP;
		next_supplies.sensor = next_state != PS_SLEEP && ctrl[CTRL_SENSOR];
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			key_q <= 1'b0;
			key_cnt <= 16'h0000;
			state <= PS_SLEEP;
			supplies <= '0;
			power_on_reset <= 1'b0;
			outputs_enable <= 1'b0;
			relay_two_enable <= 1'b0;
			open_load_detect_en <= 1'b1;
		end else begin
			key_q <= next_key_q;
			key_cnt <= next_key_cnt;
			state <= next_state;
			supplies <= next_supplies;
			power_on_reset <= next_por;
			// outputs held off in the power-on reset cycle
			outputs_enable <= next_state == PS_NORMAL && !next_por;
			relay_two_enable <= (next_state == PS_NORMAL && !next_por)
				|| (next_state == PS_PREP && relay_two_shutdown_disable);
			open_load_detect_en <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] next_ctrl, next_key_cfg, next_status;
	logic [6:0] next_duty;
	wire self_test = ctrl[CTRL_SELF_TEST];
	always_comb begin
		next_ctrl = ctrl;
		next_key_cfg = key_cfg;
		next_duty = duty;
		next_status = status;
		if (self_test) begin
			if (commit && wr_addr == REG_STATUS)
				next_status = wr_data;
		end else begin
			next_status[3:0] = status[3:0];
			if (commit && wr_addr == REG_STATUS)
				next_status[3:0] = status[3:0] & wr_data[3:0];
			// set wins over a clear in the same cycle
			next_status[3:0] = next_status[3:0] | fault_in;
			next_status[ST_KEY_LOW] = !key_q;
			next_status[ST_PWREN] = ctrl[CTRL_PWREN];
			next_status[ST_PIN] = key_status_output_pin;
			next_status[ST_ANY] = |next_status[3:0];
		end
		if (commit) begin
			unique case (wr_addr)
				REG_CTRL1: next_ctrl = wr_data;
				REG_KEY_CFG: next_key_cfg = wr_data;
				REG_DUTY: next_duty = wr_data[6:0];
				default: ;
			endcase
		end
		if (watchdog_reset)
			next_ctrl[CTRL_SELF_TEST] = 1'b0;
		if (self_test && !next_ctrl[CTRL_SELF_TEST])
			next_status = STATUS_RESET;
	end
	always_ff @(posedge clk) begin
		if (rst || power_on_reset) begin
			ctrl <= CTRL1_RESET;
			key_cfg <= KEY_CFG_RESET;
			duty <= DUTY_RESET;
			status <= STATUS_RESET;
		end else begin
			ctrl <= next_ctrl;
			key_cfg <= next_key_cfg;
			duty <= next_duty;
			status <= next_status;
		end
	end

	// ----------------------------------------------------------------
	// key-status pin and pwm
	// ----------------------------------------------------------------
	// one phase step per 1% of period; external mode steps per rising pin edge
	logic [9:0] tick_cnt, next_tick_cnt;
	logic [6:0] phase, next_phase;
	logic next_pin, step;
	logic [6:0] duty_sat;
	always_comb begin
		duty_sat = duty > DUTY_MAX ? DUTY_MAX : duty;
		next_tick_cnt = tick_cnt + 10'h001;
		step = 1'b0;
		unique case (key_cfg[1:0])
			PWM_SLOW: step = tick_cnt == 10'(PWM_SLOW_TICK - 1);
			PWM_FAST: step = tick_cnt == 10'(PWM_FAST_TICK - 1);
			PWM_EXT: step = pin_s[2] && !ext_d;
			PWM_NONE: step = 1'b0;
		endcase
		if (step || key_cfg[1:0] == PWM_EXT || key_cfg[1:0] == PWM_NONE)
			next_tick_cnt = 10'h000;
		next_phase = phase;
		if (step)
			next_phase = phase == 7'(PWM_STEPS - 1) ? 7'h00 : phase + 7'h01;
		if (state != PS_NORMAL)
			next_pin = 1'b0;
		else if (!key_cfg[CFG_HSD])
			next_pin = key_q;
		else if (!ctrl[CTRL_KEY_OUT_ON])
			next_pin = 1'b0;
		else if (key_cfg[1:0] == PWM_NONE)
			next_pin = 1'b1;
		else
			next_pin = phase < duty_sat;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_cnt <= 10'h000;
			phase <= 7'h00;
			key_status_output_pin <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			phase <= next_phase;
			key_status_output_pin <= next_pin;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_WAKE_POR: assert property (
		$rose(state == PS_NORMAL) && $past(state) == PS_SLEEP
		|-> power_on_reset && supplies.regulator)
		else $error("wake from sleep without power-on reset");
	AST_KEY_FILTER: assert property (
		$changed(key_q) |-> $past(key_cnt) == 16'(KEY_FILTER_CYCLES - 1))
		else $error("key level taken before filter time");
	AST_NORMAL_SUPPLIES: assert property (
		state == PS_NORMAL |-> supplies.regulator && supplies.host)
		else $error("supplies off in normal state");
	AST_POR_DEFAULTS: assert property (
		power_on_reset |-> !outputs_enable ##1 ctrl == CTRL1_RESET
		&& key_cfg == KEY_CFG_RESET && duty == DUTY_RESET)
		else $error("registers not at defaults after power-on reset");
	AST_SLEEP_OFF: assert property (
		state == PS_SLEEP |-> supplies == '0 && !outputs_enable
		&& !relay_two_enable ##1 !key_status_output_pin)
		else $error("sleep state left something on");
	AST_PREP: assert property (
		state == PS_PREP |-> supplies.host && !outputs_enable)
		else $error("prepare state supply or output wrong");
	AST_PREP_EXIT: assert property (
		state == PS_PREP && !ctrl[CTRL_PWREN] && !key_q
		|=> state == PS_SLEEP)
		else $error("hold bit cleared but no sleep");
	AST_KEY_STATUS: assert property (
		!$past(self_test) && !$past(self_test, 2) && !$past(power_on_reset)
		|-> status[ST_KEY_LOW] == !$past(key_q))
		else $error("status key bit does not track key");
	AST_CLEAR_ONLY: assert property (
		!$past(self_test) |-> (status[3:0] & ~$past(status[3:0])
		& ~$past(fault_in)) == 4'h0)
		else $error("status bit set without fault source");
	AST_WD_CLEAR: assert property (
		watchdog_reset |=> !self_test)
		else $error("watchdog reset left self-test on");
	AST_HSD_OFF: assert property (
		$past(state == PS_NORMAL && key_cfg[CFG_HSD]
		&& !ctrl[CTRL_KEY_OUT_ON]) |-> !key_status_output_pin)
		else $error("high-side pin on while switched off");

endmodule : power_state_controller

// [rtl/power_state_pkg.sv]
package power_state_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int PWM_STEPS = 100;
	localparam int PWM_SLOW_HZ = 100;
	localparam int PWM_FAST_HZ = 1000;
	localparam int PWM_SLOW_TICK = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
	localparam int PWM_FAST_TICK = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
	localparam int KEY_FILTER_DEFAULT = 100;

	// ----------------------------------------------------------------
	// register numbers and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL1 = 4'h1;
	localparam logic [3:0] REG_KEY_CFG = 4'h6;
	localparam logic [3:0] REG_DUTY = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hD;
	localparam logic [7:0] CTRL1_RESET = 8'h12;
	localparam logic [7:0] KEY_CFG_RESET = 8'h00;
	localparam logic [6:0] DUTY_RESET = 7'h00;
	localparam logic [7:0] STATUS_RESET = 8'h40;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PWREN = 7;
	localparam int CTRL_SELF_TEST = 6;
	localparam int CTRL_SENSOR = 4;
	localparam int CTRL_KEY_OUT_ON = 2;
	localparam int CFG_HSD = 7;
	localparam int ST_ANY = 7;
	localparam int ST_KEY_LOW = 6;
	localparam int ST_PWREN = 5;
	localparam int ST_PIN = 4;
	localparam logic [1:0] PWM_NONE = 2'b00;
	localparam logic [1:0] PWM_SLOW = 2'b01;
	localparam logic [1:0] PWM_FAST = 2'b10;
	localparam logic [1:0] PWM_EXT = 2'b11;
	localparam logic [6:0] DUTY_MAX = 7'h64;

	// ----------------------------------------------------------------
	// spi frame
	// ----------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam int FRAME_WR = 15;

	typedef enum logic [1:0] {PS_SLEEP, PS_NORMAL, PS_PREP} power_state_t;

	typedef struct packed {
		logic regulator;
		logic host;
		logic sensor;
	} supplies_t;

endpackage : power_state_pkg

// [testbench/power_state_controller_test.sv]
`timescale 1ns/1ns
module power_state_controller_test
	import power_state_pkg::*;
;
	localparam int FILTER = 4;
	logic clk, rst, key_switch_in, battery_supply, ext_pwm_in, ext_run;
	logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe;
	logic watchdog_reset, relay_two_shutdown_disable;
	logic [3:0] fault_in;
	supplies_t supplies;
	power_state_t state;
	logic outputs_enable, relay_two_enable, open_load_detect_en;
	logic power_on_reset, key_status_output_pin;
	logic [15:0] rx;
	int errors, checked;

	power_state_controller #(.KEY_FILTER_CYCLES(FILTER))
		u_power_state_controller (
		.clk(clk), .rst(rst), .key_switch_in(key_switch_in),
		.battery_supply(battery_supply), .ext_pwm_in(ext_pwm_in),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .fault_in(fault_in),
		.watchdog_reset(watchdog_reset),
		.relay_two_shutdown_disable(relay_two_shutdown_disable),
		.supplies(supplies), .outputs_enable(outputs_enable),
		.relay_two_enable(relay_two_enable),
		.open_load_detect_en(open_load_detect_en),
		.power_on_reset(power_on_reset), .state(state),
		.key_status_output_pin(key_status_output_pin));

	spi_host u_spi_host (.clk(clk), .sclk(spi_sclk), .cs_n(spi_cs_n),
		.si(spi_si), .so(spi_so));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// external reference: one period every 8 clocks while enabled
	initial begin
		ext_pwm_in = 1'b0;
		forever begin
			repeat (4) @(posedge clk);
			ext_pwm_in <= ext_run & ~ext_pwm_in;
		end
	end

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		print_verdict();
	end

	// ------
	// tasks
	// ------
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t ns: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [3:0] r, input logic [7:0] d);
		u_spi_host.xfer({4'h8, r, d}, rx);
	endtask : wr

	// the answer comes one frame late, so a second frame fetches it
	task rchk(input logic [3:0] r, input logic [7:0] e);
		u_spi_host.xfer({4'h0, r, 8'h00}, rx);
		u_spi_host.xfer(16'h0000, rx);
		chk(rx, {8'h00, e});
	endtask : rchk

	// state, supplies, outputs, relay, key pin, open-load detect
	// so enable must be low as well, since no frame is open here
	task outs(input logic [8:0] e);
		@(negedge clk);
		chk({6'h00, spi_so_oe, state, supplies, outputs_enable,
			relay_two_enable, key_status_output_pin,
			open_load_detect_en}, {7'h00, e});
		@(posedge clk);
	endtask : outs

	// counts high cycles of the key pin or of the reset pulse
	task tally(input logic pin, input int n, input int e);
		int c;
		c = 0;
		repeat (n) begin
			@(negedge clk);
			c += int'((pin ? key_status_output_pin : power_on_reset) === 1'b1);
		end
		chk(16'(c), 16'(e));
		@(posedge clk);
	endtask : tally

	task done(input string s);
		$display("%s finished, %0d mismatches so far", s, errors);
	endtask : done

	task print_verdict;
		$display("%0d checks, %0d mismatches", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	// ------
	// tests
	// ------
	initial begin
		errors = 0;
		checked = 0;
		ext_run = 1'b0;
		rst = 1'b1;
		key_switch_in = 1'b0;
		battery_supply = 1'b0;
		fault_in = 4'h0;
		watchdog_reset = 1'b0;
		relay_two_shutdown_disable = 1'b0;
		tick(2);
		rst <= 1'b0;
		tick(3);
		outs({PS_SLEEP, 7'h01});
		rchk(REG_CTRL1, CTRL1_RESET);
		rchk(REG_KEY_CFG, 8'h00);
		rchk(REG_DUTY, 8'h00);
		rchk(REG_STATUS, STATUS_RESET);
		key_switch_in <= 1'b1;
		tally(1'b0, 20, 0);
		key_switch_in <= 1'b0;
		tally(1'b0, 20, 0);
		battery_supply <= 1'b1;
		key_switch_in <= 1'b1;
		tick(2);
		key_switch_in <= 1'b0;
		tally(1'b0, 20, 0);
		key_switch_in <= 1'b1;
		tally(1'b0, FILTER + 1, 0);
		tally(1'b0, 12, 1);
		outs({PS_NORMAL, 7'h7F});
		rchk(REG_STATUS, 8'h10);
		done("power up");
		fault_in <= 4'h5;
		tick(1);
		fault_in <= 4'h0;
		rchk(REG_STATUS, 8'h95);
		wr(REG_STATUS, 8'hFE);
		rchk(REG_STATUS, 8'h94);
		wr(REG_STATUS, 8'h0B);
		rchk(REG_STATUS, 8'h10);
		wr(4'h3, 8'hFF);
		rchk(4'h3, 8'h00);
		// first self-test is ended by the host, the second by a watchdog reset
		wr(REG_CTRL1, 8'h52);
		wr(REG_STATUS, 8'hAB);
		fault_in <= 4'h4;
		tick(1);
		fault_in <= 4'h0;
		rchk(REG_STATUS, 8'hAB);
		wr(REG_CTRL1, 8'h12);
		rchk(REG_STATUS, 8'h10);
		wr(REG_CTRL1, 8'h52);
		wr(REG_STATUS, 8'h0F);
		watchdog_reset <= 1'b1;
		tick(1);
		watchdog_reset <= 1'b0;
		rchk(REG_CTRL1, 8'h12);
		rchk(REG_STATUS, 8'h10);
		done("status");
		wr(REG_KEY_CFG, 8'h80);
		tally(1'b1, 100, 0);
		wr(REG_CTRL1, 8'h16);
		tally(1'b1, 100, 100);
		wr(REG_DUTY, 8'd50);
		wr(REG_KEY_CFG, 8'h82);
		tally(1'b1, 10000, 5000);
		wr(REG_DUTY, 8'd127);
		tally(1'b1, 1000, 1000);
		wr(REG_DUTY, 8'd25);
		ext_run <= 1'b1;
		wr(REG_KEY_CFG, 8'h83);
		tally(1'b1, 800, 200);
		wr(REG_DUTY, 8'd100);
		wr(REG_KEY_CFG, 8'h81);
		tally(1'b1, 1000, 1000);
		ext_run <= 1'b0;
		wr(REG_KEY_CFG, 8'h00);
		tally(1'b1, 100, 100);
		// sensor supply follows its control bit in normal state
		wr(REG_CTRL1, 8'h02);
		outs({PS_NORMAL, 7'h6F});
		done("key pin");
		wr(REG_CTRL1, 8'h92);
		rchk(REG_STATUS, 8'h30);
		key_switch_in <= 1'b0;
		tally(1'b0, 20, 0);
		outs({PS_PREP, 7'h71});
		relay_two_shutdown_disable <= 1'b1;
		tick(2);
		outs({PS_PREP, 7'h75});
		rchk(REG_STATUS, 8'h60);
		key_switch_in <= 1'b1;
		tally(1'b0, 20, 0);
		outs({PS_NORMAL, 7'h7F});
		key_switch_in <= 1'b0;
		tally(1'b0, 20, 0);
		wr(REG_CTRL1, 8'h12);
		outs({PS_SLEEP, 7'h01});
		key_switch_in <= 1'b1;
		tally(1'b0, 20, 1);
		rchk(REG_DUTY, 8'h00);
		key_switch_in <= 1'b0;
		tally(1'b0, 20, 0);
		outs({PS_SLEEP, 7'h01});
		done("shutdown");
		print_verdict();
	end
endmodule : power_state_controller_test

// [testbench/spi_host.sv]
`timescale 1ns/1ns
// ------
// host side spi master, mode 0, 16-bit frames
// ------
module spi_host #(
	parameter int HALF = 4
) (
	// clock
	input wire logic clk,
	// spi pins
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// HALF clocks high and twice HALF low keeps sclk under clk/4; raise it to go slow
	task xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (HALF) @(posedge clk);
			si <= tx[i];
			repeat (HALF - 1) @(posedge clk);
			@(negedge clk);
			rx[i] = so;
			@(posedge clk);
			sclk <= 1'b1;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		// a released data line must not keep showing the last bit
		si <= ~si;
		repeat (2 * HALF) @(posedge clk);
	endtask : xfer
endmodule : spi_host
